// ---- src/err_status_pkg.sv ----
// Register map, field positions and reset values of the error status block
// Assumes a 32-bit APB register bus with one register per aligned word
package err_status_pkg;
  // ----------------------------------------------------------------------
  // Register word index and byte offsets
  // ----------------------------------------------------------------------
  // Status register index; its word sits at four times the index
  localparam logic [11:0] ERROR_INTERRUPT_STATUS_OFS = 12'h7e2;
  localparam logic [12:0] STATUS_WORD_ADDR           = 13'h1f88;
  localparam logic [12:0] ERROR_COUNT_LOW_ADDR       = 13'h0800;
  localparam logic [12:0] ERROR_COUNT_HIGH_ADDR      = 13'h0804;
  localparam logic [12:0] ERROR_CONTROL_ADDR         = 13'h0808;
  localparam logic [12:0] IRQ_MASK_ADDR              = 13'h080c;
  localparam logic [12:0] IRQ_PENDING_ADDR           = 13'h0810;

  // ----------------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------------
  localparam int SYS_BPV_BIT   = 5;
  localparam int LINE_BPV_BIT  = 4;
  localparam int SYS_EXZ_BIT   = 3;
  localparam int LINE_EXZ_BIT  = 2;
  localparam int PATTERN_BIT   = 1;
  localparam int OVERFLOW_BIT  = 0;
  localparam int NUM_EVENTS    = 6;

  // Control field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SNAP_BIT = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [5:0]  MASK_RESET    = 6'h00;
  localparam logic [7:0]  STATUS_RSVD   = 8'hc0;
endpackage : err_status_pkg

// ---- src/error_counter.sv ----
// Sixteen-bit running error counter with overflow pulse and snapshot view
// Assumes error strobes are synchronous one-cycle pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module error_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Counting
  input  wire logic             err_pulse,
  input  wire logic             auto_mode,
  input  wire logic             snap_req,
  // Results
  output logic [WIDTH-1:0]      shown_count,
  output logic                  overflow_pulse
);
  import err_status_pkg::*;

  logic [WIDTH-1:0] run_reg;
  logic [WIDTH-1:0] run_next;
  logic             wrap;

  // Running count wraps; the wrap is reported as overflow
  assign wrap     = err_pulse && (run_reg == {WIDTH{1'b1}});
  assign run_next = run_reg + WIDTH'(1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_reg        <= '0;
      overflow_pulse <= 1'b0;
    end
    else
    begin
      if (err_pulse)
        run_reg <= run_next;
      overflow_pulse <= wrap;
    end
  end

  // Shown value follows the count live or only on a manual snapshot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shown_count <= '0;
    else if (auto_mode || snap_req)
      shown_count <= err_pulse ? run_next : run_reg;
  end
endmodule : error_counter
`default_nettype wire

// ---- src/line_error_interrupt_status_counter.sv ----
// Line error interrupt status and error counter register bank
// Assumes a single pclk domain, APB master, and one-cycle event pulses
//
// What this block does
// - Bit 5 flags system-side bipolar violation, drives irq, write one clears.
// - Bit 4 flags line-side bipolar violation; write one clears it.
// - Bit 3 flags system-side excessive zeros; write one clears it.
// - Bit 2 flags line-side excessive zeros; write one clears it.
// - Bit 1 flags pattern checker error, drives irq, write one clears.
// - Bit 0 flags sixteen-bit error counter overflow; write one clears.
// - Status bits 7 and 6 are reserved and read zero.
// - Low error count byte is read-only and resets to zero.
// - Count view updates automatically or on manual request per mode bit.
// - High error count byte is separate, read-only, resets to zero.
`timescale 1ns/1ps
`default_nettype none
module line_error_interrupt_status_counter #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [12:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Line events, one-cycle pulses
  input  wire logic        sys_bpv_event,
  input  wire logic        line_bpv_event,
  input  wire logic        sys_exz_event,
  input  wire logic        line_exz_event,
  input  wire logic        pattern_err_event,
  // Interrupt
  output logic             irq
);
  import err_status_pkg::*;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        access;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_status;
  logic        hit_low;
  logic        hit_high;
  logic        hit_ctrl;
  logic        hit_mask;
  logic        hit_pend;
  logic        mapped;

  assign access     = psel && penable;
  assign wr_acc     = access && pwrite;
  assign rd_acc     = access && !pwrite;
  assign hit_status = (paddr == STATUS_WORD_ADDR);
  assign hit_low    = (paddr == ERROR_COUNT_LOW_ADDR);
  assign hit_high   = (paddr == ERROR_COUNT_HIGH_ADDR);
  assign hit_ctrl   = (paddr == ERROR_CONTROL_ADDR);
  assign hit_mask   = (paddr == IRQ_MASK_ADDR);
  assign hit_pend   = (paddr == IRQ_PENDING_ADDR);
  assign mapped     = hit_status | hit_low | hit_high | hit_ctrl |
                      hit_mask | hit_pend;

  // ----------------------------------------------------------------------
  // Register map, byte addresses of aligned 32-bit words
  // ----------------------------------------------------------------------
  // Status word   : flags in bits 5..0, write one clears, reads keep them
  // Count low     : low byte of the visible count, read-only
  // Count high    : high byte of the visible count, read-only
  // Control       : bit 0 selects live view, bit 1 asks for one snapshot
  // Mask          : bits 5..0 enable the matching pending bit onto irq
  // Pending       : bits 5..0 copy each event, cleared by reading them
  //
  // The status word keeps its flags sticky for software that polls, while
  // the pending copy lets an interrupt handler acknowledge with one read.
  // Bits 31..8 of every word read zero and ignore writes.
  // Unmapped addresses answer with an error and change nothing.
  //
  // Timing: an event in cycle n shows in the status word from cycle n+1;
  // read data is captured in the setup cycle and stands in the access
  // cycle, so a read reports the state as it was one cycle earlier.

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------------
  // Control, mask and counter
  // ----------------------------------------------------------------------
  logic                   mode_reg;
  logic                   snap_pulse;
  logic [NUM_EVENTS-1:0]  mask_reg;
  logic [COUNT_WIDTH-1:0] count_view;
  logic                   ovf_pulse;

  // Mode bit held; snapshot bit is self-clearing so each write asks once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg   <= 1'b0;
      snap_pulse <= 1'b0;
      mask_reg   <= MASK_RESET;
    end
    else
    begin
      snap_pulse <= wr_acc && hit_ctrl && pstrb[0] && pwdata[CTRL_SNAP_BIT];
      if (wr_acc && hit_ctrl && pstrb[0])
        mode_reg <= pwdata[CTRL_MODE_BIT];
      if (wr_acc && hit_mask && pstrb[0])
        mask_reg <= pwdata[NUM_EVENTS-1:0];
    end
  end

  error_counter #(
    .WIDTH (COUNT_WIDTH)
  ) error_counter_i (
    .pclk           (pclk),
    .presetn        (presetn),
    .err_pulse      (pattern_err_event),
    .auto_mode      (mode_reg),
    .snap_req       (snap_pulse),
    .shown_count    (count_view),
    .overflow_pulse (ovf_pulse)
  );

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] status_reg;
  logic [NUM_EVENTS-1:0] w1c;
  logic                  stat_wr;

  assign events[SYS_BPV_BIT]  = sys_bpv_event;
  assign events[LINE_BPV_BIT] = line_bpv_event;
  assign events[SYS_EXZ_BIT]  = sys_exz_event;
  assign events[LINE_EXZ_BIT] = line_exz_event;
  assign events[PATTERN_BIT]  = pattern_err_event;
  assign events[OVERFLOW_BIT] = ovf_pulse;

  // Status byte fills lane 0 of its own aligned word
  assign stat_wr = wr_acc && hit_status && pstrb[0];
  assign w1c     = stat_wr ? pwdata[NUM_EVENTS-1:0] : '0;

  // Set wins over a same-cycle clear so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++)
    begin : g_flag
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          status_reg[gi] <= STATUS_RESET[gi];
        else if (events[gi])
          status_reg[gi] <= 1'b1;
        else if (w1c[gi])
          status_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pending copy for the interrupt line, cleared by reading it
  // ----------------------------------------------------------------------
  logic [NUM_EVENTS-1:0] pend_reg;
  logic                  pend_rd;
  logic [31:0]           prdata_reg;
  logic [NUM_EVENTS-1:0] pend_ack;

  assign pend_rd  = rd_acc && hit_pend;
  // Only bits that the read reported are cleared, so an event that lands
  // between setup and access is not lost
  assign pend_ack = pend_rd ? prdata_reg[NUM_EVENTS-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= '0;
    else
      pend_reg <= (pend_reg & ~pend_ack) | events;
  end

  // Level interrupt while any unmasked pending bit stands
  assign irq = |(pend_reg & mask_reg);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0]  status_byte;
  logic [31:0] rd_next;

  // Reserved bits read as zero
  assign status_byte = {2'b00, status_reg} & ~STATUS_RSVD;

  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (hit_status)
      rd_next = {24'h000000, status_byte};
    else if (hit_low)
      rd_next = {24'h000000, count_view[7:0]};
    else if (hit_high)
      rd_next = {24'h000000, count_view[15:8]};
    else if (hit_ctrl)
      rd_next = {31'h0, mode_reg};
    else if (hit_mask)
      rd_next = {26'h0, mask_reg};
    else if (hit_pend)
      rd_next = {26'h0, pend_reg};
  end

  // Read data is taken in the setup cycle so the output leaves a flop;
  // it stands through the access cycle and returns to zero afterwards
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_reg <= rd_next;
    else
      prdata_reg <= 32'h0000_0000;
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sys_bpv_set: assert property (sys_bpv_event |=> status_reg[5])
    else $error("system bipolar flag not set");
  a_line_bpv_clear: assert property (
    stat_wr && pwdata[4] && !line_bpv_event |=> !status_reg[4])
    else $error("line bipolar flag not cleared");
  a_sys_exz_set: assert property (sys_exz_event |=> status_reg[3])
    else $error("system zeros flag not set");
  a_line_exz_set: assert property (line_exz_event |=> status_reg[2])
    else $error("line zeros flag not set");
  a_pattern_irq: assert property (
    pattern_err_event && mask_reg[1] |=> irq)
    else $error("pattern error did not raise irq");
  a_overflow_set: assert property (ovf_pulse |=> status_reg[0])
    else $error("overflow flag not set");
  a_reserved_zero: assert property (
    rd_acc && hit_status |-> prdata[7:6] == 2'b00)
    else $error("reserved status bits nonzero");
  a_manual_hold: assert property (
    !mode_reg && !snap_pulse |=> $stable(count_view))
    else $error("count view moved in manual mode");
  a_flag_sticky: assert property (
    status_reg[3] && !(stat_wr && pwdata[3]) |=> status_reg[3])
    else $error("flag dropped without write one");

  // Set and clear of every remaining flag, plus the system bipolar irq check
  a_line_bpv_set: assert property (line_bpv_event |=> status_reg[4])
    else $error("line bipolar flag not set");
  a_pattern_set: assert property (pattern_err_event |=> status_reg[1])
    else $error("pattern flag not set");
  a_sys_bpv_irq: assert property (
    sys_bpv_event && mask_reg[5] |=> irq)
    else $error("system bipolar event did not raise irq");
  a_sys_bpv_clear: assert property (
    stat_wr && pwdata[5] && !sys_bpv_event |=> !status_reg[5])
    else $error("system bipolar flag not cleared");
  a_sys_exz_clear: assert property (
    stat_wr && pwdata[3] && !sys_exz_event |=> !status_reg[3])
    else $error("system zeros flag not cleared");
  a_line_exz_clear: assert property (
    stat_wr && pwdata[2] && !line_exz_event |=> !status_reg[2])
    else $error("line zeros flag not cleared");
  a_pattern_clear: assert property (
    stat_wr && pwdata[1] && !pattern_err_event |=> !status_reg[1])
    else $error("pattern flag not cleared");
  a_overflow_clear: assert property (
    stat_wr && pwdata[0] && !ovf_pulse |=> !status_reg[0])
    else $error("overflow flag not cleared");

  // A status read never drops a flag
  a_read_keeps: assert property (
    rd_acc && hit_status |=>
      status_reg == ($past(status_reg) | $past(events)))
    else $error("status read changed flags");

  // A zero write to bit 5 leaves a set system bipolar flag alone
  a_zero_keeps: assert property (
    status_reg[5] && stat_wr && !pwdata[5] |=> status_reg[5])
    else $error("zero write dropped flag");

  c_flag_clear: cover property (status_reg[5] ##1 !status_reg[5]);
  c_irq_raise:  cover property (!irq ##1 irq);
  c_overflow:   cover property (ovf_pulse);
  c_snapshot:   cover property (snap_pulse && !mode_reg);
endmodule : line_error_interrupt_status_counter
`default_nettype wire

// ---- test/line_error_interrupt_status_counter_bench.sv ----
// Self-checking bench for the line error status and counter bank
// Assumes a zero-wait APB slave, one pclk domain, one-cycle event pulses
`timescale 1ns/1ps
`default_nettype none
module line_error_interrupt_status_counter_bench;
  import err_status_pkg::*;
  // ------------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  ev = 5'h00;
  logic        irq;
  logic [32:0] exp_q[$];
  logic [15:0] seed = 16'hcac3;
  logic [15:0] cnt;
  logic [7:0]  f;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #2 pclk = ~pclk;

  line_error_interrupt_status_counter #(.COUNT_WIDTH(16))
    line_error_interrupt_status_counter_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_bpv_event(ev[4]), .line_bpv_event(ev[3]),
    .sys_exz_event(ev[2]), .line_exz_event(ev[1]),
    .pattern_err_event(ev[0]), .irq(irq));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [32:0] st(input logic [7:0] v);
    return {25'h0, v};
  endfunction : st

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic test_done();
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // One APB transfer; a read notes its expected {pslverr, prdata} first
  task automatic bus(input logic w, input logic [12:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [32:0] e);
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  // Hold one event input high for m cycles; a level counts every cycle
  task automatic hold(input int k, input int m);
    @(posedge pclk);
    ev[k] <= 1'b1;
    repeat (m) @(posedge pclk);
    ev[k] <= 1'b0;
  endtask : hold

  // Read results are compared against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, exp_q.pop_front());

  // Hang guard: the overflow run alone needs about 65536 cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fails++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, STATUS_WORD_ADDR, 0, 0, st(STATUS_RESET));
    bus(1'b0, ERROR_COUNT_LOW_ADDR, 0, 0, {25'h0, COUNT_RESET[7:0]});
    bus(1'b0, ERROR_COUNT_HIGH_ADDR, 0, 0, {25'h0, COUNT_RESET[15:8]});
    bus(1'b0, 13'h0900, 0, 0, {1'b1, 32'h0});
    bus(1'b1, IRQ_MASK_ADDR, 32'h20, 4'h1, 0);
    // Each event sets its own flag; only the unmasked one raises irq
    for (int k = 0; k < 5; k++)
    begin
      f = 8'h01 << (k + 1);
      hold(k, 1);
      @(negedge pclk);
      check({32'h0, irq}, {32'h0, k == 4});
      bus(1'b0, STATUS_WORD_ADDR, 0, 0, st(f));
      bus(1'b1, STATUS_WORD_ADDR, 0, 4'h1, 0);
      bus(1'b0, STATUS_WORD_ADDR, 0, 0, st(f));
      bus(1'b0, IRQ_PENDING_ADDR, 0, 0, {27'h0, f[5:0]});
      bus(1'b1, STATUS_WORD_ADDR, {24'h0, f}, 4'h1, 0);
      bus(1'b0, STATUS_WORD_ADDR, 0, 0, st(8'h00));
      @(negedge pclk);
      check({32'h0, irq}, 33'h0);
    end
    // Auto mode then snapshot mode, random burst length
    cnt = 16'h0001;
    bus(1'b1, ERROR_CONTROL_ADDR, 32'h1, 4'h1, 0);
    seed = lfsr(seed);
    hold(0, 1 + seed[5:0]);
    cnt = cnt + 16'(1 + seed[5:0]);
    repeat (3) @(posedge pclk);
    bus(1'b0, ERROR_COUNT_LOW_ADDR, 0, 0, {25'h0, cnt[7:0]});
    bus(1'b0, ERROR_COUNT_HIGH_ADDR, 0, 0, {25'h0, cnt[15:8]});
    bus(1'b1, ERROR_CONTROL_ADDR, 32'h2, 4'h1, 0);
    hold(0, 3);
    bus(1'b0, ERROR_COUNT_LOW_ADDR, 0, 0, {25'h0, cnt[7:0]});
    cnt = cnt + 16'h0003;
    bus(1'b1, ERROR_CONTROL_ADDR, 32'h2, 4'h1, 0);
    bus(1'b0, ERROR_COUNT_LOW_ADDR, 0, 0, {25'h0, cnt[7:0]});
    // Wrap the sixteen-bit count to reach overflow
    bus(1'b1, STATUS_WORD_ADDR, 32'h2, 4'h1, 0);
    bus(1'b1, ERROR_CONTROL_ADDR, 32'h1, 4'h1, 0);
    hold(0, 65536 - int'(cnt));
    repeat (4) @(posedge pclk);
    bus(1'b0, STATUS_WORD_ADDR, 0, 0, st(8'h03));
    bus(1'b0, ERROR_COUNT_LOW_ADDR, 0, 0, 33'h0);
    bus(1'b0, ERROR_COUNT_HIGH_ADDR, 0, 0, 33'h0);
    bus(1'b1, STATUS_WORD_ADDR, 32'h1, 4'h1, 0);
    bus(1'b0, STATUS_WORD_ADDR, 0, 0, st(8'h02));
    test_done();
  end
endmodule : line_error_interrupt_status_counter_bench
`default_nettype wire
